// [rtl/occ_pkg.sv]
/*
 * Shared constants and types of the oscillator select and PLL translation
 * block: register offsets, field positions, reset values and the crystal
 * code lookup.
 * Assumes a 32-bit register port with byte addresses and one core clock.
 */
package occ_pkg;

	// Register byte offsets.
	localparam logic [11:0] OCC_OFS_RUN_CFG = 12'h060;
	localparam logic [11:0] OCC_OFS_XLATE = 12'h064;
	localparam int OCC_ADDR_W = 12;

	// Field positions of the run clock configuration register.
	localparam int OCC_POS_MAIN_DIS = 0;
	localparam int OCC_POS_INT_DIS = 1;
	localparam int OCC_POS_SRC_LO = 4;
	localparam int OCC_POS_CRYSTAL_FREQ_CODE_LO = 6;
	localparam int OCC_POS_BYPASS = 11;
	localparam int OCC_POS_RSV_ONE = 12;
	localparam int OCC_POS_PWRDN = 13;

	// Field positions of the translation register.
	localparam int OCC_POS_R_LO = 0;
	localparam int OCC_POS_F_LO = 5;

	// Oscillator source encodings.
	localparam logic [1:0] OCC_SRC_MAIN = 2'h0;
	localparam logic [1:0] OCC_SRC_INT = 2'h1;
	localparam logic [1:0] OCC_SRC_INT_DIV4 = 2'h2;
	localparam logic [1:0] OCC_SRC_30K = 2'h3;

	// Reset values of the configuration fields.
	localparam logic OCC_RST_MAIN_DIS = 1'h1;
	localparam logic OCC_RST_INT_DIS = 1'h0;
	localparam logic [1:0] OCC_RST_SRC = OCC_SRC_INT;
	localparam logic [3:0] OCC_RST_CRYSTAL_FREQ_CODE = 4'hb;
	localparam logic OCC_RST_BYPASS = 1'h1;
	localparam logic OCC_RST_PWRDN = 1'h1;

	// Nominal PLL multiplier; the divider picks the reference per crystal.
	localparam logic [8:0] OCC_PLL_F_NOM = 9'h18e;

	// Software-visible configuration fields.
	typedef struct packed {
		logic pwrdn;
		logic bypass;
		logic [3:0] crystal_freq_code;
		logic [1:0] src;
		logic int_dis;
		logic main_dis;
	} occ_cfg_s;

	// Values driven to the PLL inputs.
	typedef struct packed {
		logic [8:0] f;
		logic [4:0] r;
	} occ_pll_s;

	// Register port request.
	typedef struct packed {
		logic [OCC_ADDR_W-1:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} occ_bus_s;

	// Crystal code to PLL multiplier and divider; codes 0x0 to 0x3 give 0.
	function automatic occ_pll_s occ_crystal_freq_code_lookup(input logic [3:0] code);
		occ_pll_s v;
		v.f = OCC_PLL_F_NOM;
		unique case (code)
			4'h4, 4'h5: v.r = 5'h02;
			4'h6, 4'h7: v.r = 5'h03;
			4'h8, 4'h9, 4'ha: v.r = 5'h04;
			4'hb, 4'hc: v.r = 5'h05;
			4'hd: v.r = 5'h06;
			4'he, 4'hf: v.r = 5'h07;
			default:
			begin
				v.f = 9'h000;
				v.r = 5'h00;
			end
		endcase
		return v;
	endfunction

	// Translation held while reset is applied.
	localparam occ_pll_s OCC_RST_PLL = occ_crystal_freq_code_lookup(OCC_RST_CRYSTAL_FREQ_CODE);

endpackage

// [rtl/occ_top.sv]
/*
 * Oscillator source selection and crystal to PLL translation: holds the
 * run clock configuration fields, the read-only translation register and
 * the selects and enables for the oscillators, PLL and system clock mux.
 * Assumes a register master on the core clock that uses one-cycle strobes,
 * never both at once, and takes read data in the cycle after the strobe.
 */
`timescale 1ns/100ps

// Summary of operation
// - Two-bit field selects main, internal, internal/4 or 30 kHz source.
// - Internal oscillator runs while its disable bit is 0; resets to 0.
// - Main oscillator stops while its disable bit is 1; resets to 1.
// - Crystal codes 0x8 to 0xF map to PLL settings; 0xB is reset value.
// - Translation register holds the reset code's values when reset ends.
// - A new crystal code written by software recomputes the translation.
// - Multiplier sits in bits 13:5 and drives the PLL multiplier.
// - Divider sits in translation bits 4:0 and drives the PLL divider.
// - Translation bits 31:14 read zero; software preserves reserved bits.
// - Bypass set clocks system from oscillator, clear from divided PLL.
module occ_top
	import occ_pkg::*;
(
	input wire logic i_core_clk, // Core clock, 200 MHz.
	input wire logic i_rst_n, // Asynchronous reset, active low.
	input wire logic i_clk_en, // Clock enable; all state holds while low.
	input wire occ_bus_s i_bus, // Register request: address, data, strobes.
	output logic [31:0] o_rdata, // Read data, valid the cycle after a read.
	output logic [1:0] o_osc_source_select, // Oscillator mux select.
	output logic o_internal_osc_en, // Internal oscillator run enable.
	output logic o_main_osc_en, // Main oscillator run enable.
	output logic o_sys_from_pll, // System clock from divided PLL output.
	output logic o_pll_pwrdn, // PLL power down.
	output logic o_pll_src_bad, // Undivided internal oscillator feeds PLL while bypass is clear.
	output occ_pll_s o_pll // PLL multiplier and input divider.
);

	// All state of the register side.
	typedef struct packed {
		occ_cfg_s cfg;
		logic [31:0] rdata;
		logic src_bad;
	} occ_state_s;

	occ_state_s st_r;
	occ_state_s st_nxt;
	occ_pll_s pll_w;
	logic hit_cfg;
	logic hit_xl;

	// Packs the configuration fields into their register image.
	function automatic logic [31:0] cfg_image(input occ_cfg_s c);
		logic [31:0] v;
		v = 32'h0000_0000;
		v[OCC_POS_MAIN_DIS] = c.main_dis;
		v[OCC_POS_INT_DIS] = c.int_dis;
		v[OCC_POS_SRC_LO +: 2] = c.src;
		v[OCC_POS_CRYSTAL_FREQ_CODE_LO +: 4] = c.crystal_freq_code;
		v[OCC_POS_BYPASS] = c.bypass;
		v[OCC_POS_RSV_ONE] = 1'h1;
		v[OCC_POS_PWRDN] = c.pwrdn;
		return v;
	endfunction

	// Places the PLL values in the translation image, upper bits zero.
	function automatic logic [31:0] xl_image(input occ_pll_s p);
		logic [31:0] v;
		v = 32'h0000_0000;
		v[OCC_POS_F_LO +: 9] = p.f;
		v[OCC_POS_R_LO +: 5] = p.r;
		return v;
	endfunction

	// Address decode of the two mapped registers.
	assign hit_cfg = (i_bus.addr == OCC_OFS_RUN_CFG);
	assign hit_xl = (i_bus.addr == OCC_OFS_XLATE);

	// Translation unit follows the stored crystal code.
	occ_xlate u_xlate
	(
		.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n),
		.i_clk_en(i_clk_en),
		.i_crystal_freq_code(st_r.cfg.crystal_freq_code),
		.o_pll(pll_w)
	);

	// Register writes, read data capture and the source hazard flag.
	always_comb
	begin
		st_nxt = st_r;
		if (i_bus.wr && hit_cfg)
		begin
			st_nxt.cfg.main_dis = i_bus.wdata[OCC_POS_MAIN_DIS];
			st_nxt.cfg.int_dis = i_bus.wdata[OCC_POS_INT_DIS];
			st_nxt.cfg.src = i_bus.wdata[OCC_POS_SRC_LO +: 2];
			st_nxt.cfg.crystal_freq_code = i_bus.wdata[OCC_POS_CRYSTAL_FREQ_CODE_LO +: 4];
			st_nxt.cfg.bypass = i_bus.wdata[OCC_POS_BYPASS];
			st_nxt.cfg.pwrdn = i_bus.wdata[OCC_POS_PWRDN];
		end
		// A write to the translation offset falls through untouched.
		if (i_bus.rd)
		begin
			if (hit_cfg)
				st_nxt.rdata = cfg_image(st_r.cfg);
			else if (hit_xl)
				st_nxt.rdata = xl_image(pll_w);
			else
				st_nxt.rdata = 32'h0000_0000;
		end
		// The PLL needs the divided internal oscillator, never the raw one.
		st_nxt.src_bad = !st_nxt.cfg.bypass &&
			(st_nxt.cfg.src == OCC_SRC_INT);
	end

	// State register; reset gives the documented field defaults.
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			st_r.cfg.main_dis <= OCC_RST_MAIN_DIS;
			st_r.cfg.int_dis <= OCC_RST_INT_DIS;
			st_r.cfg.src <= OCC_RST_SRC;
			st_r.cfg.crystal_freq_code <= OCC_RST_CRYSTAL_FREQ_CODE;
			st_r.cfg.bypass <= OCC_RST_BYPASS;
			st_r.cfg.pwrdn <= OCC_RST_PWRDN;
			st_r.rdata <= 32'h0000_0000;
			st_r.src_bad <= 1'h0;
		end
		else if (i_clk_en)
			st_r <= st_nxt;
	end

	// Outputs toward the oscillators, the PLL and the system clock mux.
	assign o_rdata = st_r.rdata;
	assign o_osc_source_select = st_r.cfg.src;
	assign o_internal_osc_en = !st_r.cfg.int_dis;
	assign o_main_osc_en = !st_r.cfg.main_dis;
	assign o_sys_from_pll = !st_r.cfg.bypass;
	assign o_pll_pwrdn = st_r.cfg.pwrdn;
	assign o_pll_src_bad = st_r.src_bad;
	assign o_pll = pll_w;

	// Checks on the enabled path from a register write to the outputs.
	property p_src_write;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_bus.wr && hit_cfg && i_clk_en) |=>
			o_osc_source_select == $past(i_bus.wdata[OCC_POS_SRC_LO +: 2]);
	endproperty
	a_src_write: assert property (p_src_write)
		else $error("Source select does not follow the written field.");

	property p_internal_oscillator_write;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_bus.wr && hit_cfg && i_clk_en) |=>
			o_internal_osc_en != $past(i_bus.wdata[OCC_POS_INT_DIS]);
	endproperty
	a_internal_oscillator_write: assert property (p_internal_oscillator_write)
		else $error("Internal oscillator enable wrong after write.");

	property p_mosc_write;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_bus.wr && hit_cfg && i_clk_en) |=>
			o_main_osc_en != $past(i_bus.wdata[OCC_POS_MAIN_DIS]);
	endproperty
	a_mosc_write: assert property (p_mosc_write)
		else $error("Main oscillator enable wrong after write.");

	property p_mosc_reset;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		!$past(i_rst_n) |-> !o_main_osc_en && o_internal_osc_en &&
			o_osc_source_select == OCC_SRC_INT;
	endproperty
	a_mosc_reset: assert property (p_mosc_reset)
		else $error("Oscillator controls not at reset defaults.");

	// A new code reaches the PLL inputs two enabled cycles after the write.
	sequence s_crystal_freq_code_write;
		(i_bus.wr && hit_cfg && i_clk_en) ##1 i_clk_en;
	endsequence

	property p_crystal_freq_code_update;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		s_crystal_freq_code_write |=> o_pll ==
			occ_crystal_freq_code_lookup($past(i_bus.wdata[OCC_POS_CRYSTAL_FREQ_CODE_LO +: 4], 2));
	endproperty
	a_crystal_freq_code_update: assert property (p_crystal_freq_code_update)
		else $error("Translation did not follow the new crystal code.");

	property p_rd_f;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_bus.rd && hit_xl && i_clk_en) |=>
			o_rdata[OCC_POS_F_LO +: 9] == $past(o_pll.f);
	endproperty
	a_rd_f: assert property (p_rd_f)
		else $error("Read multiplier differs from the PLL input.");

	property p_rd_r;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_bus.rd && hit_xl && i_clk_en) |=>
			o_rdata[OCC_POS_R_LO +: 5] == $past(o_pll.r);
	endproperty
	a_rd_r: assert property (p_rd_r)
		else $error("Read divider differs from the PLL input.");

	property p_rd_rsv;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_bus.rd && hit_xl && i_clk_en) |=>
			o_rdata[31:OCC_POS_F_LO + 9] == 18'h00000;
	endproperty
	a_rd_rsv: assert property (p_rd_rsv)
		else $error("Reserved translation bits read nonzero.");

	property p_bypass;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_bus.wr && hit_cfg && i_clk_en) |=>
			o_sys_from_pll == !$past(i_bus.wdata[OCC_POS_BYPASS]);
	endproperty
	a_bypass: assert property (p_bypass)
		else $error("System clock select does not follow bypass.");

	property p_xl_write_ignored;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_bus.wr && hit_xl && i_clk_en) |=> ##1 $stable(o_pll);
	endproperty
	a_xl_write_ignored: assert property (p_xl_write_ignored)
		else $error("Write to the translation register changed it.");

	// Read-back of the configuration fields against the live controls.
	property p_rd_src;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_bus.rd && hit_cfg && i_clk_en) |=>
			o_rdata[OCC_POS_SRC_LO +: 2] == $past(o_osc_source_select);
	endproperty
	a_rd_src: assert property (p_rd_src)
		else $error("Read source field differs from the mux select.");

	property p_rd_int_dis;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_bus.rd && hit_cfg && i_clk_en) |=>
			o_rdata[OCC_POS_INT_DIS] == !$past(o_internal_osc_en);
	endproperty
	a_rd_int_dis: assert property (p_rd_int_dis)
		else $error("Read internal disable differs from the enable.");

	property p_rd_main_dis;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_bus.rd && hit_cfg && i_clk_en) |=>
			o_rdata[OCC_POS_MAIN_DIS] == !$past(o_main_osc_en);
	endproperty
	a_rd_main_dis: assert property (p_rd_main_dis)
		else $error("Read main disable differs from the enable.");

	property p_rd_bypass;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_bus.rd && hit_cfg && i_clk_en) |=>
			o_rdata[OCC_POS_BYPASS] == !$past(o_sys_from_pll);
	endproperty
	a_rd_bypass: assert property (p_rd_bypass)
		else $error("Read bypass bit differs from the clock select.");

	property p_rd_pwrdn;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_bus.rd && hit_cfg && i_clk_en) |=>
			o_rdata[OCC_POS_PWRDN] == $past(o_pll_pwrdn);
	endproperty
	a_rd_pwrdn: assert property (p_rd_pwrdn)
		else $error("Read power down bit differs from the PLL input.");

	// Unused configuration bits read fixed values; bit 12 reads one.
	property p_rd_cfg_rsv;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_bus.rd && hit_cfg && i_clk_en) |=> o_rdata[OCC_POS_RSV_ONE] &&
			o_rdata[31:OCC_POS_PWRDN + 1] == 18'h00000 &&
			o_rdata[OCC_POS_BYPASS - 1] == 1'h0 &&
			o_rdata[OCC_POS_INT_DIS + 1 +: 2] == 2'h0;
	endproperty
	a_rd_cfg_rsv: assert property (p_rd_cfg_rsv)
		else $error("Unused configuration bits read wrong.");

	property p_rd_unmapped;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_bus.rd && !hit_cfg && !hit_xl && i_clk_en) |=>
			o_rdata == 32'h0000_0000;
	endproperty
	a_rd_unmapped: assert property (p_rd_unmapped)
		else $error("Unmapped read returned nonzero data.");

	property p_rdata_hold;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(!i_bus.rd || !i_clk_en) |=> $stable(o_rdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold)
		else $error("Read data changed without a taken read.");

	// A translation write must leave every oscillator control alone.
	property p_xl_write_cfg;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_bus.wr && hit_xl && i_clk_en) |=> $stable(o_osc_source_select) &&
			$stable(o_main_osc_en) && $stable(o_internal_osc_en) &&
			$stable(o_sys_from_pll) && $stable(o_pll_pwrdn);
	endproperty
	a_xl_write_cfg: assert property (p_xl_write_cfg)
		else $error("Write to the translation register changed controls.");

	property p_src_bad;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		o_pll_src_bad == (o_sys_from_pll && o_osc_source_select == OCC_SRC_INT);
	endproperty
	a_src_bad: assert property (p_src_bad)
		else $error("Undivided source flag wrong for the PLL path.");

	property p_reset_clk_path;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		!$past(i_rst_n) |-> !o_sys_from_pll && o_pll_pwrdn && !o_pll_src_bad;
	endproperty
	a_reset_clk_path: assert property (p_reset_clk_path)
		else $error("System clock path not at reset defaults.");

	// Every code from 0x8 up gives a usable multiplier and divider.
	property p_code_ranges;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		s_crystal_freq_code_write ##1
			($past(i_bus.wdata[OCC_POS_CRYSTAL_FREQ_CODE_LO +: 4], 2) >= 4'h8) |->
			o_pll.f != 9'h000 && o_pll.r != 5'h00;
	endproperty
	a_code_ranges: assert property (p_code_ranges)
		else $error("Documented crystal code gave a zero PLL setting.");

	property p_pll_freeze;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		!i_clk_en |=> $stable(o_pll) && $stable(o_rdata) &&
			$stable(o_osc_source_select);
	endproperty
	a_pll_freeze: assert property (p_pll_freeze)
		else $error("State moved while the clock enable was low.");

	// Main scenarios worth seeing in simulation.
	c_crystal_freq_code_change: cover property (@(posedge i_core_clk) disable iff
		(!i_rst_n) s_crystal_freq_code_write ##1 $changed(o_pll));
	c_rd_xlate: cover property (@(posedge i_core_clk) disable iff
		(!i_rst_n) i_bus.rd && hit_xl && i_clk_en);
	c_pll_path: cover property (@(posedge i_core_clk) disable iff
		(!i_rst_n) o_sys_from_pll && o_osc_source_select == OCC_SRC_INT_DIV4);
	c_src_bad: cover property (@(posedge i_core_clk) disable iff
		(!i_rst_n) o_pll_src_bad);

endmodule

// [rtl/occ_xlate.sv]
/*
 * Crystal code to PLL translation unit: looks up the multiplier and input
 * divider for the crystal code and holds them in a register.
 * Assumes the code comes from logic on the same clock.
 */
`timescale 1ns/100ps

module occ_xlate
	import occ_pkg::*;
(
	input wire logic i_core_clk, // Core clock.
	input wire logic i_rst_n, // Asynchronous reset, active low.
	input wire logic i_clk_en, // Clock enable; state holds while low.
	input wire logic [3:0] i_crystal_freq_code, // Current crystal code.
	output occ_pll_s o_pll // Registered multiplier and divider.
);

	// All state of the unit.
	typedef struct packed {
		occ_pll_s pll;
	} occ_xl_state_s;

	occ_xl_state_s st_r;
	occ_xl_state_s st_nxt;

	// The lookup follows the code every enabled cycle.
	always_comb
	begin
		st_nxt = st_r;
		// Fixed table of the code.
		st_nxt.pll = occ_crystal_freq_code_lookup(i_crystal_freq_code);
	end

	// The reset value is the translation of the reset crystal code.
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			st_r <= '{pll: OCC_RST_PLL};
		else if (i_clk_en)
			st_r <= st_nxt;
	end

	assign o_pll = st_r.pll;

	property p_xlate_lookup;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		$past(i_clk_en) |-> o_pll == occ_crystal_freq_code_lookup($past(i_crystal_freq_code));
	endproperty
	a_xlate_lookup: assert property (p_xlate_lookup)
		else $error("Translation does not match the previous crystal code.");

	property p_xlate_reset;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		!$past(i_rst_n) |-> o_pll == OCC_RST_PLL;
	endproperty
	a_xlate_reset: assert property (p_xlate_reset)
		else $error("Translation not loaded with the reset crystal code.");

endmodule

// [test/occ_osc_pll_model.sv]
/*
 * Far-side model of the oscillators and the PLL: reports lock a few
 * cycles after the PLL is powered up with a usable multiplier.
 * Assumes the PLL inputs come from the block on the same core clock.
 */
`timescale 1ns/100ps

module occ_osc_pll_model
	import occ_pkg::*;
(
	input wire logic i_core_clk, // Core clock.
	input wire logic i_rst_n, // Asynchronous reset, active low.
	input wire logic i_pll_pwrdn, // PLL power down.
	input wire occ_pll_s i_pll, // Multiplier and divider.
	output logic o_pll_locked // High once the PLL has settled.
);
	logic [3:0] lock_cnt_r;

	// A zero multiplier never locks, so a bad crystal code shows up here.
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			lock_cnt_r <= 4'h0;
		else if (i_pll_pwrdn || i_pll.f == 9'h000)
			lock_cnt_r <= 4'h0;
		else if (lock_cnt_r != 4'hf)
			lock_cnt_r <= lock_cnt_r + 4'h1;
	end

	assign o_pll_locked = (lock_cnt_r == 4'hf); // Settled after 15 cycles.
endmodule

// [test/test_osc_select_pll_translation.sv]
/*
 * Self-checking bench of the oscillator select and PLL translation block.
 * Assumes the block answers reads one cycle after the strobe.
 */
`timescale 1ns/100ps

module test_osc_select_pll_translation;
	import occ_pkg::*;
	logic i_core_clk, i_rst_n, i_clk_en, locked;
	occ_bus_s i_bus;
	logic [31:0] o_rdata, rd_val, last_cfg;
	logic [1:0] o_osc_source_select, s;
	logic o_internal_osc_en, o_main_osc_en, o_sys_from_pll;
	logic o_pll_pwrdn, o_pll_src_bad, byp;
	occ_pll_s o_pll;
	int failures, samples_checked;

	occ_top dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
		.i_clk_en(i_clk_en), .i_bus(i_bus), .o_rdata(o_rdata),
		.o_osc_source_select(o_osc_source_select),
		.o_internal_osc_en(o_internal_osc_en),
		.o_main_osc_en(o_main_osc_en), .o_sys_from_pll(o_sys_from_pll),
		.o_pll_pwrdn(o_pll_pwrdn), .o_pll_src_bad(o_pll_src_bad),
		.o_pll(o_pll));
	occ_osc_pll_model far_side (.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n), .i_pll_pwrdn(o_pll_pwrdn), .i_pll(o_pll),
		.o_pll_locked(locked));

	// Free-running 200 MHz core clock.
	initial
	begin
		i_core_clk = 1'b0;
		forever #2.5 i_core_clk = ~i_core_clk;
	end

	// Configuration image; bit 12 is written as it reads.
	function automatic logic [31:0] cfg_img(logic md, logic id,
		logic [1:0] sr, logic [3:0] x, logic bp, logic pd);
		return {18'h0, pd, 1'b1, bp, 1'b0, x, sr, 2'h0, id, md};
	endfunction

	// Expected translation image for a crystal code.
	function automatic logic [31:0] xl_img(logic [3:0] c);
		logic [4:0] r;
		case (c)
			4'h4, 4'h5: r = 5'h02;
			4'h6, 4'h7: r = 5'h03;
			4'h8, 4'h9, 4'ha: r = 5'h04;
			4'hb, 4'hc: r = 5'h05;
			4'hd: r = 5'h06;
			4'he, 4'hf: r = 5'h07;
			default: r = 5'h00;
		endcase
		return {18'h0, (c < 4'h4) ? 9'h000 : OCC_PLL_F_NOM, r};
	endfunction

	// One write cycle, then one idle cycle.
	task automatic bus_wr(input logic [11:0] a, input logic [31:0] d);
		i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge i_core_clk);
		i_bus.wr <= 1'b0;
		@(posedge i_core_clk);
	endtask

	// One read cycle; data are taken in the cycle after the strobe.
	task automatic bus_rd(input logic [11:0] a, output logic [31:0] d);
		i_bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge i_core_clk);
		i_bus.rd <= 1'b0;
		@(posedge i_core_clk);
		d = o_rdata;
	endtask

	// Compares one value and counts it.
	task automatic chk_val(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic final_report();
		$display("Checked %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Cuts a hang short well past the expected run length.
	initial
	begin
		repeat (5000) @(posedge i_core_clk);
		failures++;
		$display("Error watchdog expected finish seen timeout");
		final_report();
	end

	// Main test sequence.
	initial
	begin
		i_rst_n = 1'b0;
		i_clk_en = 1'b1;
		i_bus = '0;
		failures = 0;
		samples_checked = 0;
		repeat (3) @(posedge i_core_clk);
		i_rst_n <= 1'b1;
		@(posedge i_core_clk);
		chk_val("reset pll", xl_img(4'hb), {18'h0, o_pll});
		bus_rd(OCC_OFS_RUN_CFG, rd_val);
		chk_val("reset cfg", 32'h3ad1, rd_val);
		bus_rd(OCC_OFS_XLATE, rd_val);
		chk_val("reset xlate", xl_img(4'hb), rd_val);
		$display("Test reset done");
		for (int c = 0; c < 16; c++)
		begin
			last_cfg = cfg_img(1'b1, 1'b0, 2'h1, c[3:0], 1'b1, 1'b1);
			bus_wr(OCC_OFS_RUN_CFG, last_cfg);
			@(posedge i_core_clk);
			chk_val("pll port", xl_img(c[3:0]), {18'h0, o_pll});
			bus_rd(OCC_OFS_XLATE, rd_val);
			chk_val("xlate", xl_img(c[3:0]), rd_val);
			bus_rd(OCC_OFS_RUN_CFG, rd_val);
			chk_val("cfg", last_cfg, rd_val);
		end
		$display("Test crystal codes done");
		for (int k = 0; k < 16; k++)
		begin
			s = k[1:0];
			byp = k[1] ^ k[3];
			last_cfg = cfg_img(k[3], k[2], s, 4'hb, byp, 1'b0);
			bus_wr(OCC_OFS_RUN_CFG, last_cfg);
			@(posedge i_core_clk);
			chk_val("osc ports", {25'h0, s, ~k[2], ~k[3], ~byp, 1'b0,
				~byp & (s == OCC_SRC_INT)}, {25'h0, o_osc_source_select,
				o_internal_osc_en, o_main_osc_en, o_sys_from_pll,
				o_pll_pwrdn, o_pll_src_bad});
		end
		repeat (40) @(posedge i_core_clk);
		chk_val("pll lock", 32'h1, {31'h0, locked});
		$display("Test sources done");
		bus_wr(OCC_OFS_XLATE, 32'hffff_ffff);
		@(posedge i_core_clk);
		chk_val("pll after wr", xl_img(4'hb), {18'h0, o_pll});
		bus_rd(OCC_OFS_XLATE, rd_val);
		chk_val("xlate after wr", xl_img(4'hb), rd_val);
		bus_rd(12'h100, rd_val);
		chk_val("unmapped", 32'h0, rd_val);
		i_clk_en <= 1'b0;
		bus_wr(OCC_OFS_RUN_CFG, cfg_img(1'b0, 1'b0, 2'h2, 4'h8, 1'b0,
			1'b1));
		i_clk_en <= 1'b1;
		bus_rd(OCC_OFS_RUN_CFG, rd_val);
		chk_val("cfg gated", last_cfg, rd_val);
		$display("Test refusals done");
		bus_wr(OCC_OFS_RUN_CFG, cfg_img(1'b0, 1'b0, 2'h2, 4'h8, 1'b0,
			1'b0));
		@(posedge i_core_clk);
		chk_val("pll code 8", xl_img(4'h8), {18'h0, o_pll});
		i_rst_n <= 1'b0;
		repeat (3) @(posedge i_core_clk);
		i_rst_n <= 1'b1;
		@(posedge i_core_clk);
		chk_val("pll rerun", xl_img(4'hb), {18'h0, o_pll});
		bus_rd(OCC_OFS_RUN_CFG, rd_val);
		chk_val("cfg rerun", 32'h3ad1, rd_val);
		$display("Test mid-run reset done");
		final_report();
	end
endmodule
